// ---- pt32_front.sv ----
`timescale 1ns/10ps
`default_nettype none
module pt32_front (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic pin,
  input wire logic clock_source_select,
  input wire logic gate_accumulate,
  input wire logic [1:0] prescale_select,
  output logic tick,
  output logic gate_fall
);
  logic pin_q;
  logic [7:0] ps_cnt;
  logic gated;
  logic raw;
  logic [7:0] limit;

  // Previous pin level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  // Gating only applies with the internal clock selected
  assign gated = gate_accumulate & ~clock_source_select; // see [RULE_12]
  // External source counts rising edges; gated internal counts while pin high
  assign raw = clock_source_select ? (pin & ~pin_q) : (gated ? pin : 1'b1); // see [RULE_15]
  assign limit = pt32_pkg::ps_limit(prescale_select);

  // Prescaler, cleared while stopped so a restart begins a full period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_cnt <= pt32_pkg::PS_LIMIT_1;
    end else if (!run) begin
      ps_cnt <= pt32_pkg::PS_LIMIT_1;
    end else if (raw) begin
      ps_cnt <= (ps_cnt >= limit) ? pt32_pkg::PS_LIMIT_1 : ps_cnt + 8'h01; // see [RULE_13]
    end
  end

  assign tick = run & raw & (ps_cnt >= limit); // see [RULE_13]
  assign gate_fall = run & gated & ~pin & pin_q; // see [RULE_21]
endmodule : pt32_front
`default_nettype wire

// ---- pt32_pkg.sv ----
package pt32_pkg;
  // Register byte offsets on the APB map
  localparam logic [7:0] OFS_CTRL_EVEN = 8'h00;
  localparam logic [7:0] OFS_CTRL_ODD = 8'h04;
  localparam logic [7:0] OFS_PER_EVEN = 8'h08;
  localparam logic [7:0] OFS_PER_ODD = 8'h0C;
  localparam logic [7:0] OFS_CNT_EVEN = 8'h10;
  localparam logic [7:0] OFS_CNT_ODD = 8'h14;
  localparam logic [7:0] OFS_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CFG = 8'h1C;

  // Control register field positions
  localparam int BIT_RUN_ON = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int BIT_GATE_ACCUMULATE = 6;
  localparam int BIT_PRESCALE_HI = 5;
  localparam int BIT_PRESCALE_LO = 4;
  localparam int BIT_PAIR_JOIN = 3;
  localparam int BIT_CLOCK_SOURCE = 1;

  // Writable bits; everything else reads as zero
  localparam logic [15:0] CTRL_MASK_EVEN = 16'hA07A;
  localparam logic [15:0] CTRL_MASK_ODD = 16'hA072;

  // Interrupt config fields
  localparam int BIT_IE_EVEN = 0;
  localparam int BIT_IE_ODD = 1;
  localparam int BIT_PRIO_EVEN_LO = 4;
  localparam int BIT_PRIO_ODD_LO = 8;

  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PER_RESET = 16'h0000;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [2:0] PRIO_RESET = 3'h0;

  // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
  localparam logic [7:0] PS_LIMIT_1 = 8'h00;
  localparam logic [7:0] PS_LIMIT_8 = 8'h07;
  localparam logic [7:0] PS_LIMIT_64 = 8'h3F;
  localparam logic [7:0] PS_LIMIT_256 = 8'hFF;

  // Pair that feeds capture/compare, DMA and converter 1; pair that feeds converter 2
  localparam int PAIR_TB_DMA_ADC1 = 1;
  localparam int PAIR_ADC2 = 2;

  typedef enum logic [1:0] {
    PT32_PS_DIV1 = 2'b00,
    PT32_PS_DIV8 = 2'b01,
    PT32_PS_DIV64 = 2'b10,
    PT32_PS_DIV256 = 2'b11
  } pt32_ps_t;

  function automatic logic [7:0] ps_limit(input logic [1:0] code);
    case (pt32_ps_t'(code))
      PT32_PS_DIV1: ps_limit = PS_LIMIT_1;
      PT32_PS_DIV8: ps_limit = PS_LIMIT_8;
      PT32_PS_DIV64: ps_limit = PS_LIMIT_64;
      PT32_PS_DIV256: ps_limit = PS_LIMIT_256;
      default: ps_limit = PS_LIMIT_1;
    endcase
  endfunction : ps_limit
endpackage : pt32_pkg

// ---- pt32_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} pt32_row_t;
  typedef struct {logic [15:0] c; logic [15:0] per; int iv;} pt32_ps_row_t;
  logic pclk, presetn, psel, penable, pwrite, idle_mode, ext_e, ext_o, pready, pslverr, e;
  logic irq_even, irq_odd, adc1, adc2, dma;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, x;
  logic [2:0] pe, po;
  logic [15:0] tbe, tbo;
  int errors, n_tests, cyc, n_dma, n_adc1, n_adc2, iv, t;
  logic adc1_b, adc2_b, dma_b;
  logic [15:0] tbe_b, tbo_b;
  int n_adc2_b, n_other_b;
  pt32_row_t rows [8];
  pt32_ps_row_t psr [4];

  pt32_top #(.PAIR_INDEX(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .external_timer_clock_pin_even(ext_e), .external_timer_clock_pin_odd(ext_o),
    .irq_even(irq_even), .irq_odd(irq_odd), .timer_irq_priority_even(pe), .timer_irq_priority_odd(po),
    .adc1_trigger(adc1), .adc2_trigger(adc2), .dma_request(dma), .time_base_even(tbe), .time_base_odd(tbo));

  // Second pair on the same bus: converter 2 trigger only, no DMA, no time base
  pt32_top #(.PAIR_INDEX(2)) dut_b (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .idle_mode(idle_mode), .external_timer_clock_pin_even(ext_e), .external_timer_clock_pin_odd(ext_o),
    .irq_even(), .irq_odd(), .timer_irq_priority_even(), .timer_irq_priority_odd(),
    .adc1_trigger(adc1_b), .adc2_trigger(adc2_b), .dma_request(dma_b),
    .time_base_even(tbe_b), .time_base_odd(tbo_b));

  // Free-running 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // Pulse counters; pulses last one cycle so they are counted at every edge
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (dma === 1'b1) n_dma <= n_dma + 1;
    if (adc1 === 1'b1) n_adc1 <= n_adc1 + 1;
    if (adc2 === 1'b1) n_adc2 <= n_adc2 + 1;
    if (adc2_b === 1'b1) n_adc2_b <= n_adc2_b + 1;
    if ((adc1_b | dma_b) === 1'b1) n_other_b <= n_other_b + 1;
  end

  task give_verdict();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // One APB transfer; read data and error taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin errors++; $display("wrong value pready exp 1 got 0"); give_verdict(); end
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Bounded wait for an interrupt line; a hang ends the run
  task automatic wait_irq(input logic s);
    int k;
    k = 0;
    while (((s ? irq_odd : irq_even) !== 1'b1) && k < 100) begin @(posedge pclk); k++; end
    n_tests++;
    if (k >= 100) begin errors++; $display("wrong value irq exp 1 got 0"); give_verdict(); end
  endtask : wait_irq

  // Cycles between two successive flag events, seen through the DMA pulse
  task automatic measure();
    int c, k;
    k = 0;
    c = n_dma;
    while (n_dma == c && k < 600) begin @(posedge pclk); k++; end
    t = cyc;
    c = n_dma;
    while (n_dma == c && k < 1200) begin @(posedge pclk); k++; end
    iv = cyc - t;
    if (k >= 1200) begin errors++; $display("wrong value dma pulse exp 1 got 0"); give_verdict(); end
  endtask : measure

  task pin_pulse();
    @(posedge pclk); ext_e <= 1'b1;
    repeat (2) @(posedge pclk);
    ext_e <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pin_pulse

  task done(input string s);
    $display("test %s done, errors so far %0d", s, errors);
  endtask : done

  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    idle_mode = 1'b0; ext_e = 1'b0; ext_o = 1'b0; presetn = 1'b0;
    // Writes with the run bit clear, so nothing counts while the map is probed
    rows[0] = '{pt32_pkg::OFS_CTRL_EVEN, 32'h0000_7FFF, 32'h0000_207A, 1'b0};
    rows[1] = '{pt32_pkg::OFS_CTRL_ODD, 32'h0000_7FFF, 32'h0000_2072, 1'b0};
    rows[2] = '{pt32_pkg::OFS_PER_EVEN, 32'hFFFF_1234, 32'h0000_1234, 1'b0};
    rows[3] = '{pt32_pkg::OFS_PER_ODD, 32'h0000_5678, 32'h0000_5678, 1'b0};
    rows[4] = '{pt32_pkg::OFS_CNT_EVEN, 32'h0000_0005, 32'h0000_0005, 1'b0};
    rows[5] = '{pt32_pkg::OFS_CNT_ODD, 32'h0000_0006, 32'h0000_0006, 1'b0};
    rows[6] = '{pt32_pkg::OFS_IRQ_CFG, 32'h0000_0FFF, 32'h0000_0773, 1'b0};
    rows[7] = '{8'h20, 32'h0000_FFFF, 32'h0000_0000, 1'b1};
    psr[0] = '{16'h8000, 16'h0002, 3};
    psr[1] = '{16'h8010, 16'h0001, 16};
    psr[2] = '{16'h8020, 16'h0000, 64};
    psr[3] = '{16'h8030, 16'h0000, 256};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // Every register reads zero after reset
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      `CHK("reset value", 32'h0000_0000, r)
    end
    done("reset");
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      `CHK("write error", rows[i].e, e)
      rd(rows[i].a);
      `CHK("readback", rows[i].x, r)
      `CHK("read error", rows[i].e, e)
    end
    `CHK("priority even", 3'h7, pe)
    `CHK("priority odd", 3'h7, po)
    done("register map");
    // Two independent 16-bit timers, periods 2 and 4
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0); wr(pt32_pkg::OFS_CTRL_ODD, 32'h0);
    wr(pt32_pkg::OFS_CNT_EVEN, 32'h0); wr(pt32_pkg::OFS_CNT_ODD, 32'h0);
    wr(pt32_pkg::OFS_PER_EVEN, 32'h2); wr(pt32_pkg::OFS_PER_ODD, 32'h4);
    wr(pt32_pkg::OFS_IRQ_CFG, 32'h3);
    wr(pt32_pkg::OFS_CTRL_ODD, 32'h8000); wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8000);
    wait_irq(1'b0);
    wait_irq(1'b1);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0); wr(pt32_pkg::OFS_CTRL_ODD, 32'h0);
    rd(pt32_pkg::OFS_FLAGS);
    `CHK("flags split", 32'h3, r)
    `CHK("adc1 pulses", 1'b1, n_adc1 > 0)
    `CHK("adc2 pulses", 0, n_adc2)
    `CHK("dma pulses", 1'b1, n_dma > 0)
    `CHK("pair 2 adc2 pulses", 1'b1, n_adc2_b > 0)
    wr(pt32_pkg::OFS_FLAGS, 32'h3);
    rd(pt32_pkg::OFS_FLAGS);
    `CHK("flags cleared", 32'h0, r)
    `CHK("irq even low", 1'b0, irq_even)
    done("split");
    // Flag spacing for every prescale code and a wrap at period 2
    for (int i = 0; i < 4; i++) begin
      wr(pt32_pkg::OFS_PER_EVEN, {16'h0, psr[i].per});
      wr(pt32_pkg::OFS_CNT_EVEN, 32'h0);
      wr(pt32_pkg::OFS_CTRL_EVEN, {16'h0, psr[i].c});
      measure();
      `CHK("tick spacing", psr[i].iv, iv)
      wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0);
    end
    done("prescale");
    // Paired: carry out of the even word lands in the odd word
    wr(pt32_pkg::OFS_PER_EVEN, 32'hFFFF); wr(pt32_pkg::OFS_PER_ODD, 32'hFFFF);
    wr(pt32_pkg::OFS_CNT_EVEN, 32'hFFFE); wr(pt32_pkg::OFS_CNT_ODD, 32'h0);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0008); wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8008);
    repeat (8) @(posedge pclk);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0008);
    rd(pt32_pkg::OFS_CNT_ODD);
    `CHK("high word", 32'h1, r)
    `CHK("time base odd", 16'h0001, tbo)
    // Paired period 0x0001_0002, odd control set to run slowly and ignored
    wr(pt32_pkg::OFS_FLAGS, 32'h3); wr(pt32_pkg::OFS_IRQ_CFG, 32'h3);
    wr(pt32_pkg::OFS_PER_EVEN, 32'h2); wr(pt32_pkg::OFS_PER_ODD, 32'h1);
    wr(pt32_pkg::OFS_CNT_EVEN, 32'hFFFE); wr(pt32_pkg::OFS_CNT_ODD, 32'h0);
    wr(pt32_pkg::OFS_CTRL_ODD, 32'h8032);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8008);
    wait_irq(1'b1);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0); wr(pt32_pkg::OFS_CTRL_ODD, 32'h0);
    rd(pt32_pkg::OFS_FLAGS);
    `CHK("paired flags", 32'h2, r)
    done("paired");
    // Idle halt holds the paired count; software clears it to keep the pair running
    wr(pt32_pkg::OFS_PER_EVEN, 32'hFFFF); wr(pt32_pkg::OFS_CNT_EVEN, 32'h0);
    idle_mode <= 1'b1;
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'hA008);
    repeat (10) @(posedge pclk);
    rd(pt32_pkg::OFS_CNT_EVEN);
    `CHK("idle halted", 32'h0, r)
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8008);
    repeat (10) @(posedge pclk);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0);
    idle_mode <= 1'b0;
    rd(pt32_pkg::OFS_CNT_EVEN);
    x = r;
    `CHK("idle running", 1'b1, x != 0)
    repeat (10) @(posedge pclk);
    rd(pt32_pkg::OFS_CNT_EVEN);
    `CHK("stopped holds", x, r)
    done("idle");
    // External clock: three pin rises give three counts, gate bit ignored
    wr(pt32_pkg::OFS_CNT_EVEN, 32'h0);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8042);
    repeat (3) pin_pulse();
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0);
    rd(pt32_pkg::OFS_CNT_EVEN);
    `CHK("external count", 32'h3, r)
    `CHK("time base", 16'h0003, tbe)
    `CHK("pair 2 time base", 32'h0, {tbo_b, tbe_b})
    done("external");
    // Gated accumulation on the internal clock, interrupt on gate fall
    wr(pt32_pkg::OFS_FLAGS, 32'h3); wr(pt32_pkg::OFS_IRQ_CFG, 32'h1);
    wr(pt32_pkg::OFS_CNT_EVEN, 32'h0);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8040);
    repeat (10) @(posedge pclk);
    rd(pt32_pkg::OFS_CNT_EVEN);
    `CHK("gate closed", 32'h0, r)
    ext_e <= 1'b1;
    repeat (10) @(posedge pclk);
    ext_e <= 1'b0;
    wait_irq(1'b0);
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h0);
    rd(pt32_pkg::OFS_CNT_EVEN);
    `CHK("gate open counted", 1'b1, r != 0)
    done("gate");
    // Reset in mid-run, with a count running and the gate flag still set
    wr(pt32_pkg::OFS_CTRL_EVEN, 32'h8000);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("irq after reset", 1'b0, irq_even)
    for (int i = 0; i < 8; i++) begin
      rd(8'(i * 4));
      `CHK("mid-run reset", 32'h0000_0000, r)
    end
    `CHK("pair 2 dma and adc1", 0, n_other_b)
    done("mid-run reset");
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ---- pt32_top.sv ----
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [RULE_01] Pair splits into two 16-bit timers
// [RULE_02] Each 16-bit timer runs synchronous timer/counter
// [RULE_03] Paired: even low word, odd high word
// [RULE_04] Paired: odd control register fully ignored
// [RULE_05] Paired: even clock/gate, odd interrupt flag
// [RULE_06] Paired: interrupt on 32-bit period match
// [RULE_07] Period is odd high, even low
// [RULE_08] Count pair: odd high, even low
// [RULE_09] Run bit starts/stops timer or pair
// [RULE_10] Idle-halt bit stops timer in idle
// [RULE_11] Software clears idle-halt for paired idle running
// [RULE_12] Gate accumulate only with internal clock
// [RULE_13] Prescale codes divide 1, 8, 64, 256
// [RULE_14] Pair-join bit on even register joins timers
// [RULE_15] Clock source: external rising edge or internal
// [RULE_16] Unimplemented control bits read zero
// [RULE_17] Only first pair gives capture/compare time base
// [RULE_18] First pair triggers converter 1, second converter 2
// [RULE_19] Only first pair requests DMA transfers
// [RULE_20] Software sets run bit after other setup
// [RULE_21] Gate falling edge raises timer interrupt
// [RULE_22] Count increments, wraps at period, sets flag
module pt32_top #(
  parameter int PAIR_INDEX = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic idle_mode,
  input wire logic external_timer_clock_pin_even,
  input wire logic external_timer_clock_pin_odd,
  output logic irq_even,
  output logic irq_odd,
  output logic [2:0] timer_irq_priority_even,
  output logic [2:0] timer_irq_priority_odd,
  output logic adc1_trigger,
  output logic adc2_trigger,
  output logic dma_request,
  output logic [15:0] time_base_even,
  output logic [15:0] time_base_odd
);
  logic [15:0] ctrl_even;
  logic [15:0] ctrl_odd;
  logic [15:0] per_even;
  logic [15:0] per_odd;
  logic [15:0] cnt_even;
  logic [15:0] cnt_odd;
  logic flag_even;
  logic flag_odd;
  logic ie_even;
  logic ie_odd;
  logic [2:0] prio_even;
  logic [2:0] prio_odd;
  logic wr;
  logic pair;
  logic run_even;
  logic run_odd;
  logic tick_even;
  logic tick_odd;
  logic fall_even;
  logic fall_odd;
  logic match_even;
  logic match_odd;
  logic match32;
  logic ev_even;
  logic ev_odd;
  logic pair_match;
  logic wr_cnt_even;
  logic wr_cnt_odd;

  function automatic logic addr_ok(input logic [7:0] a);
    case (a)
      pt32_pkg::OFS_CTRL_EVEN, pt32_pkg::OFS_CTRL_ODD, pt32_pkg::OFS_PER_EVEN, pt32_pkg::OFS_PER_ODD,
      pt32_pkg::OFS_CNT_EVEN, pt32_pkg::OFS_CNT_ODD, pt32_pkg::OFS_FLAGS, pt32_pkg::OFS_IRQ_CFG: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  endfunction : addr_ok

  // Zero-wait slave; write lands on the access edge
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign wr = psel & penable & pwrite & addr_ok(paddr);
  assign wr_cnt_even = wr & (paddr == pt32_pkg::OFS_CNT_EVEN);
  assign wr_cnt_odd = wr & (paddr == pt32_pkg::OFS_CNT_ODD);

  // Mode decode
  assign pair = ctrl_even[pt32_pkg::BIT_PAIR_JOIN]; // see [RULE_14]
  assign run_even = ctrl_even[pt32_pkg::BIT_RUN_ON] & ~(ctrl_even[pt32_pkg::BIT_IDLE_HALT] & idle_mode); // see [RULE_09] [RULE_10]
  // Odd half is parked while paired, its control bits have no effect
  assign run_odd = ~pair & ctrl_odd[pt32_pkg::BIT_RUN_ON]
                   & ~(ctrl_odd[pt32_pkg::BIT_IDLE_HALT] & idle_mode); // see [RULE_04] [RULE_01]

  pt32_front u_front_even (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_even),
    .pin(external_timer_clock_pin_even),
    .clock_source_select(ctrl_even[pt32_pkg::BIT_CLOCK_SOURCE]),
    .gate_accumulate(ctrl_even[pt32_pkg::BIT_GATE_ACCUMULATE]),
    .prescale_select(ctrl_even[pt32_pkg::BIT_PRESCALE_HI:pt32_pkg::BIT_PRESCALE_LO]),
    .tick(tick_even),
    .gate_fall(fall_even)
  );

  pt32_front u_front_odd (
    .pclk(pclk),
    .presetn(presetn),
    .run(run_odd),
    .pin(external_timer_clock_pin_odd),
    .clock_source_select(ctrl_odd[pt32_pkg::BIT_CLOCK_SOURCE]),
    .gate_accumulate(ctrl_odd[pt32_pkg::BIT_GATE_ACCUMULATE]),
    .prescale_select(ctrl_odd[pt32_pkg::BIT_PRESCALE_HI:pt32_pkg::BIT_PRESCALE_LO]),
    .tick(tick_odd),
    .gate_fall(fall_odd)
  );

  // Period compare, 32-bit period is odd:even
  assign match_even = (cnt_even == per_even);
  assign match_odd = (cnt_odd == per_odd);
  assign match32 = match_even & match_odd; // see [RULE_07]
  assign pair_match = pair ? (tick_even & match32) : (tick_even & match_even);

  // Paired events go to the odd flag, the even flag stays quiet
  assign ev_even = ~pair & ((tick_even & match_even) | fall_even); // see [RULE_22]
  assign ev_odd = pair ? ((tick_even & match32) | fall_even) : ((tick_odd & match_odd) | fall_odd); // see [RULE_05] [RULE_06]

  // Control registers; unimplemented bits never store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_even <= pt32_pkg::CTRL_RESET;
      ctrl_odd <= pt32_pkg::CTRL_RESET;
    end else if (wr) begin
      if (paddr == pt32_pkg::OFS_CTRL_EVEN) begin
        ctrl_even <= pwdata[15:0] & pt32_pkg::CTRL_MASK_EVEN; // see [RULE_16]
      end
      if (paddr == pt32_pkg::OFS_CTRL_ODD) begin
        ctrl_odd <= pwdata[15:0] & pt32_pkg::CTRL_MASK_ODD; // see [RULE_16]
      end
    end
  end

  // Period registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_even <= pt32_pkg::PER_RESET;
      per_odd <= pt32_pkg::PER_RESET;
    end else if (wr) begin
      if (paddr == pt32_pkg::OFS_PER_EVEN) begin
        per_even <= pwdata[15:0];
      end
      if (paddr == pt32_pkg::OFS_PER_ODD) begin
        per_odd <= pwdata[15:0];
      end
    end
  end

  // Even count: low word when paired; software write beats a tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_even <= pt32_pkg::CNT_RESET;
    end else if (wr_cnt_even) begin
      cnt_even <= pwdata[15:0];
    end else if (tick_even) begin
      if (pair ? match32 : match_even) begin
        cnt_even <= pt32_pkg::CNT_RESET; // see [RULE_22]
      end else begin
        cnt_even <= cnt_even + 16'h0001; // see [RULE_02] [RULE_08]
      end
    end
  end

  // Odd count: carries from the even word when paired
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_odd <= pt32_pkg::CNT_RESET;
    end else if (wr_cnt_odd) begin
      cnt_odd <= pwdata[15:0];
    end else if (pair) begin
      if (tick_even & match32) begin
        cnt_odd <= pt32_pkg::CNT_RESET; // see [RULE_06]
      end else if (tick_even & (cnt_even == 16'hFFFF)) begin
        cnt_odd <= cnt_odd + 16'h0001; // see [RULE_03] [RULE_08]
      end
    end else if (tick_odd) begin
      cnt_odd <= match_odd ? pt32_pkg::CNT_RESET : cnt_odd + 16'h0001; // see [RULE_02]
    end
  end

  // Sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_even <= 1'b0;
      flag_odd <= 1'b0;
    end else begin
      flag_even <= ev_even | (flag_even & ~(wr & (paddr == pt32_pkg::OFS_FLAGS) & pwdata[0])); // see [RULE_21]
      flag_odd <= ev_odd | (flag_odd & ~(wr & (paddr == pt32_pkg::OFS_FLAGS) & pwdata[1])); // see [RULE_05]
    end
  end

  // Interrupt enable and priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ie_even <= 1'b0;
      ie_odd <= 1'b0;
      prio_even <= pt32_pkg::PRIO_RESET;
      prio_odd <= pt32_pkg::PRIO_RESET;
    end else if (wr & (paddr == pt32_pkg::OFS_IRQ_CFG)) begin
      ie_even <= pwdata[pt32_pkg::BIT_IE_EVEN];
      ie_odd <= pwdata[pt32_pkg::BIT_IE_ODD];
      prio_even <= pwdata[pt32_pkg::BIT_PRIO_EVEN_LO +: 3];
      prio_odd <= pwdata[pt32_pkg::BIT_PRIO_ODD_LO +: 3];
    end
  end

  assign irq_even = flag_even & ie_even;
  assign irq_odd = flag_odd & ie_odd; // see [RULE_05]
  assign timer_irq_priority_even = prio_even;
  assign timer_irq_priority_odd = prio_odd;

  // Peripheral trigger pulses, registered; tied off on pairs that lack them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc1_trigger <= 1'b0;
      adc2_trigger <= 1'b0;
      dma_request <= 1'b0;
    end else begin
      adc1_trigger <= (PAIR_INDEX == pt32_pkg::PAIR_TB_DMA_ADC1) & pair_match; // see [RULE_18]
      adc2_trigger <= (PAIR_INDEX == pt32_pkg::PAIR_ADC2) & pair_match; // see [RULE_18]
      dma_request <= (PAIR_INDEX == pt32_pkg::PAIR_TB_DMA_ADC1) & (ev_even | ev_odd); // see [RULE_19]
    end
  end

  // Capture/compare time base straight from the count flops
  assign time_base_even = (PAIR_INDEX == pt32_pkg::PAIR_TB_DMA_ADC1) ? cnt_even : 16'h0000; // see [RULE_17]
  assign time_base_odd = (PAIR_INDEX == pt32_pkg::PAIR_TB_DMA_ADC1) ? cnt_odd : 16'h0000; // see [RULE_17]

  // Read data captured in the setup cycle, ready for the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        pt32_pkg::OFS_CTRL_EVEN: prdata <= {16'h0000, ctrl_even};
        pt32_pkg::OFS_CTRL_ODD: prdata <= {16'h0000, ctrl_odd};
        pt32_pkg::OFS_PER_EVEN: prdata <= {16'h0000, per_even};
        pt32_pkg::OFS_PER_ODD: prdata <= {16'h0000, per_odd};
        pt32_pkg::OFS_CNT_EVEN: prdata <= {16'h0000, cnt_even};
        pt32_pkg::OFS_CNT_ODD: prdata <= {16'h0000, cnt_odd};
        pt32_pkg::OFS_FLAGS: prdata <= {30'h0, flag_odd, flag_even};
        pt32_pkg::OFS_IRQ_CFG: prdata <= {21'h0, prio_odd, 1'b0, prio_even, 2'h0, ie_odd, ie_even};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_count_wrap: assert property (tick_even & ~pair & match_even & ~wr_cnt_even |=> cnt_even == 16'h0000 && flag_even)
    else $error("16-bit count did not wrap with flag"); // see [RULE_22]
  a_count_step: assert property (tick_even & ~pair & ~match_even & ~wr_cnt_even |=> cnt_even == $past(cnt_even) + 16'h0001)
    else $error("16-bit count did not step"); // see [RULE_02]
  a_pair_match: assert property (pair & tick_even & match32 & ~wr_cnt_odd |=> flag_odd && cnt_odd == 16'h0000)
    else $error("32-bit match did not flag odd"); // see [RULE_06]
  a_pair_carry: assert property (pair & tick_even & ~match32 & (cnt_even == 16'hFFFF) & ~wr_cnt_odd
    |=> cnt_odd == $past(cnt_odd) + 16'h0001)
    else $error("High word missed carry"); // see [RULE_03]
  a_even_quiet: assert property (pair & ~flag_even |=> ~flag_even)
    else $error("Even flag set while paired"); // see [RULE_05]
  a_odd_parked: assert property (pair & ~tick_even & ~wr_cnt_odd |=> $stable(cnt_odd))
    else $error("Odd count moved on its own while paired"); // see [RULE_04]
  a_stop_hold: assert property (~ctrl_even[pt32_pkg::BIT_RUN_ON] & ~wr_cnt_even [*2] |-> $stable(cnt_even))
    else $error("Stopped timer counted"); // see [RULE_09]
  a_idle_halt: assert property (ctrl_even[pt32_pkg::BIT_IDLE_HALT] & idle_mode & ~wr_cnt_even |=> $stable(cnt_even))
    else $error("Timer ran in idle with halt set"); // see [RULE_10]
  a_reserved_zero: assert property ((ctrl_even & ~pt32_pkg::CTRL_MASK_EVEN) == 16'h0000 && (ctrl_odd & ~pt32_pkg::CTRL_MASK_ODD) == 16'h0000)
    else $error("Unimplemented control bit set"); // see [RULE_16]
  a_gate_flag: assert property (~pair & fall_even |=> flag_even)
    else $error("Gate fall missed interrupt"); // see [RULE_21]
  a_dma_scope: assert property (PAIR_INDEX != pt32_pkg::PAIR_TB_DMA_ADC1 |-> ~dma_request && ~adc1_trigger)
    else $error("Wrong pair requested DMA"); // see [RULE_19]

  c_pair_wrap: cover property (pair & tick_even & match32);
  c_single_wrap: cover property (~pair & tick_odd & match_odd);
  c_gate_fall: cover property (fall_even);
  c_flag_clear: cover property (wr & (paddr == pt32_pkg::OFS_FLAGS) & flag_odd);
endmodule : pt32_top
`default_nettype wire
